// *** src/input_debounce.sv ***
// Debounce filter for one alternate-function input pin.
// Assumes the pin is already synchronous to the clock; the limit may change at any time.
`timescale 1ns/100ps
`default_nettype none

module input_debounce (
  input wire logic clk,
  input wire logic reset,
  input wire logic raw,
  input wire logic enable,
  input wire logic [31:0] limit,
  output logic level
);

  logic [31:0] count; // Cycles the pin has differed from the filtered level
  logic [31:0] next_count;
  logic next_level;

  // Filter: the level moves only after the new value held for the whole limit
  always_comb begin
    next_count = 32'h0;
    next_level = level;
    if (!enable) begin // Debounce off: pass the pin through
      next_level = raw;
    end else if (raw != level) begin
      if (count + 32'h1 >= limit) begin
        next_level = raw;
      end else begin
        next_count = count + 32'h1;
      end
    end
    // A return to the old level leaves next_count at zero, restarting the timer
  end

  // Register stage; the idle level is high since the inputs are active low
  always_ff @(posedge clk) begin
    if (reset) begin
      count <= 32'h0;
      level <= 1'b1;
    end else begin
      count <= next_count;
      level <= next_level;
    end
  end

endmodule : input_debounce

`default_nettype wire

// *** src/seqctl_pkg.sv ***
// Shared constants and carrier types of the sequencer control register group.
// Assumes a 200 MHz system clock and a byte-wide register port from the serial front end.
package seqctl_pkg;

  // Clock rate, used to turn times into cycle counts
  localparam int CLK_MHZ = 200;

  // Debounce step: the field selects step times (field + 1)
  localparam int DEB_STEP_MS = 5;
  localparam int DEB_STEP_CYC = DEB_STEP_MS * 1000 * CLK_MHZ;

  // Press measurement step: the threshold selects step times (value + 1)
  localparam int PRESS_STEP_MS = 100;
  localparam int PRESS_STEP_CYC = PRESS_STEP_MS * 1000 * CLK_MHZ;

  // Restart delay after a forced power-down with code 10b
  localparam int RESTART_DELAY_MS = 1000;
  localparam int RESTART_DELAY_CYC = RESTART_DELAY_MS * 1000 * CLK_MHZ;

  // Register addresses
  localparam logic [7:0] ADDR_LEVELS = 8'h25;
  localparam logic [7:0] ADDR_DEBOUNCE = 8'h26;
  localparam logic [7:0] ADDR_PRESS = 8'h27;
  localparam logic [7:0] ADDR_CONTROL = 8'h28;

  // Output-level layout: channels 4..1 in the high nibble, 12..9 in the low nibble
  localparam int LVL_LOW_CH_LSB = 4;
  localparam int LVL_HIGH_CH_LSB = 0;
  localparam int NUM_CHANNELS = 12;

  // Debounce register layout
  localparam int DEB_TIME_LSB = 4;
  localparam int DEB_EN_LSB = 1;
  localparam logic [7:0] DEB_WRITABLE = 8'hfe;

  // Control register layout
  localparam int CTL_FORCE_INT_BIT = 3;
  localparam int CTL_HOLD_BIT = 2;
  localparam int CTL_SHDN_LSB = 0;
  localparam logic [7:0] CTL_WRITABLE = 8'h0f;

  // Alternate-function bit of pin 12 inside the 12..9 nibbles
  localparam int AF_PIN12 = 3;

  // Forced shutdown codes
  localparam logic [1:0] SHDN_NONE = 2'h0;
  localparam logic [1:0] SHDN_NOW = 2'h1;
  localparam logic [1:0] SHDN_DELAY = 2'h2;
  localparam logic [1:0] SHDN_WAIT = 2'h3;

  // Values loaded from non-volatile configuration at power-on
  typedef struct packed {
    logic [7:0] levels;
    logic [7:0] debounce;
    logic [7:0] press_limit;
    logic [7:0] control;
  } nvm_image_s;

  // One register access from the serial front end
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

endpackage : seqctl_pkg

// *** src/sequencer_control_regs.sv ***
// Control and configuration register group of the power sequencer.
// Assumes a serial front end delivering byte accesses, and a sequencing engine that
// reports power-up entry and power-down completion; all inputs are synchronous to MCLK.
//
// Functional notes
// - Output bit drives pin when enables clear
// - Channels 4..1 high nibble, 12..9 low
// - Writable registers read-only when group protected
// - Power-on values come from configuration image
// - Debounce time is 5 ms times (N+1)
// - Per-pin debounce enable for pins 12..10
// - Long press is at least (N+1) x 100 ms
// - Force bit pulls interrupt low unconditionally
// - Hold-active bit makes sleep pin ignored
// - Hardware sets hold-active on power-up entry
// - Host may clear hold-active, never set it
// - No button: 00 normal, 01 restore immediately
// - No button: 10 restore after one second
// - No button: 11 restore on active-low or alarm
// - Button: 00 normal, 01 immediate power-up
// - Button: 10 power-up after second or press
// - Button: 11 power-up on alarm or press
// - Pins 9..12 output only if selected
`timescale 1ns/100ps
`default_nettype none

module sequencer_control_regs #(
  parameter int DEB_STEP_CYCLES = seqctl_pkg::DEB_STEP_CYC,
  parameter int PRESS_STEP_CYCLES = seqctl_pkg::PRESS_STEP_CYC,
  parameter int RESTART_DELAY_CYCLES = seqctl_pkg::RESTART_DELAY_CYC
) (
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic NVM_LOAD,
  input wire seqctl_pkg::nvm_image_s NVM_IMAGE,
  input wire logic CTL_PROTECTED,
  input wire seqctl_pkg::reg_req_s REG_REQ,
  input wire logic [3:0] ALTFUNC_ENABLE,
  input wire logic [3:0] ALTFUNC_SELECT,
  input wire logic [11:0] POWERUP_CHANNEL_ENABLE,
  input wire logic [11:0] SLEEP_CHANNEL_ENABLE,
  input wire logic [2:0] AF_PIN_IN,
  input wire logic INTERRUPT_SOURCE_FLAGS,
  input wire logic POWERUP_ENTRY,
  input wire logic POWERDOWN_DONE,
  input wire logic ACTIVE_REQUEST_PIN,
  input wire logic RTC_ALARM,
  input wire logic SLEEP_PIN,
  output logic [7:0] REG_RDATA,
  output logic [11:0] STATIC_OUTPUT_LEVEL,
  output logic [11:0] STATIC_OUTPUT_SELECT,
  output logic [2:0] AF_INPUT_LEVEL,
  output logic SHORT_PRESS,
  output logic LONG_PRESS,
  output logic INTERRUPT_OUT_N,
  output logic SLEEP_REQUEST,
  output logic POWERDOWN_REQUEST,
  output logic POWERUP_REQUEST,
  output logic ACTIVE_OVERRIDE
);

  // Forced shutdown sequence states
  typedef enum logic [1:0] {FS_IDLE, FS_POWERDOWN, FS_DELAY, FS_WAIT_EVENT} shutdown_state_e;

  // Register contents
  logic [7:0] general_output_levels;
  logic [7:0] input_debounce_config;
  logic [7:0] long_press_threshold;
  logic [7:0] software_state_control;
  logic [7:0] next_levels;
  logic [7:0] next_debounce;
  logic [7:0] next_press;
  logic [7:0] next_control;
  logic [7:0] next_rdata;

  // Derived register fields
  logic [3:0] debounce_time;
  logic [2:0] debounce_enable_bits;
  logic [1:0] forced_shutdown_code;
  logic hold_active_bit;
  logic force_int;
  logic write_ok;
  logic shutdown_done;

  // Debounce filter outputs and the press timer
  logic [31:0] debounce_limit;
  logic [2:0] af_level;
  logic button_enabled;
  logic button_level_q;
  logic button_press;
  logic button_release;
  logic [31:0] step_count;
  logic [8:0] press_steps;
  logic [31:0] next_step_count;
  logic [8:0] next_press_steps;

  // Forced shutdown sequencer
  shutdown_state_e fs_state;
  shutdown_state_e next_fs_state;
  logic [31:0] delay_count;
  logic [31:0] next_delay_count;
  logic fs_button_mode;
  logic next_fs_button_mode;
  logic [1:0] fs_code;
  logic [1:0] next_fs_code;

  // Pin and event outputs computed each cycle, registered below
  logic [11:0] next_out_level;
  logic [11:0] next_out_select;
  logic next_short;
  logic next_long;
  logic next_pd_req;
  logic next_pu_req;
  logic next_override;

  // True when a host write targets the given address
  function automatic logic write_hit(input seqctl_pkg::reg_req_s req, input logic [7:0] addr);
    write_hit = req.wr && (req.addr == addr);
  endfunction : write_hit

  assign debounce_time = input_debounce_config[seqctl_pkg::DEB_TIME_LSB +: 4];
  assign debounce_enable_bits = input_debounce_config[seqctl_pkg::DEB_EN_LSB +: 3];
  assign forced_shutdown_code = software_state_control[seqctl_pkg::CTL_SHDN_LSB +: 2];
  assign hold_active_bit = software_state_control[seqctl_pkg::CTL_HOLD_BIT];
  assign force_int = software_state_control[seqctl_pkg::CTL_FORCE_INT_BIT];
  // Protection freezes every host write to the group
  assign write_ok = !CTL_PROTECTED;
  // Button function exists only when pin 12 is enabled and selected as button
  assign button_enabled = ALTFUNC_ENABLE[seqctl_pkg::AF_PIN12] &&
                          ALTFUNC_SELECT[seqctl_pkg::AF_PIN12];

  // Register file next state: configuration load, host writes, hardware updates
  always_comb begin
    next_levels = general_output_levels;
    next_debounce = input_debounce_config;
    next_press = long_press_threshold;
    next_control = software_state_control;
    if (NVM_LOAD) begin // Power-on values from the configuration image
      next_levels = NVM_IMAGE.levels;
      next_debounce = NVM_IMAGE.debounce & seqctl_pkg::DEB_WRITABLE;
      next_press = NVM_IMAGE.press_limit;
      next_control = NVM_IMAGE.control & seqctl_pkg::CTL_WRITABLE;
    end else begin
      if (shutdown_done) begin // Finished sequence returns the code to normal control
        next_control[seqctl_pkg::CTL_SHDN_LSB +: 2] = seqctl_pkg::SHDN_NONE;
      end
      if (write_ok) begin
        if (write_hit(REG_REQ, seqctl_pkg::ADDR_LEVELS)) begin
          next_levels = REG_REQ.wdata;
        end
        if (write_hit(REG_REQ, seqctl_pkg::ADDR_DEBOUNCE)) begin
          next_debounce = REG_REQ.wdata & seqctl_pkg::DEB_WRITABLE;
        end
        if (write_hit(REG_REQ, seqctl_pkg::ADDR_PRESS)) begin
          next_press = REG_REQ.wdata;
        end
        if (write_hit(REG_REQ, seqctl_pkg::ADDR_CONTROL)) begin
          next_control = REG_REQ.wdata & seqctl_pkg::CTL_WRITABLE;
          // A written 1 cannot raise the hold bit; only a clear lands
          next_control[seqctl_pkg::CTL_HOLD_BIT] =
            hold_active_bit & REG_REQ.wdata[seqctl_pkg::CTL_HOLD_BIT];
        end
      end
      // Power-up entry sets the hold bit and beats a same-cycle clear
      if (POWERUP_ENTRY) begin
        next_control[seqctl_pkg::CTL_HOLD_BIT] = 1'b1;
      end
    end
  end

  // Read mux; unmapped addresses read zero, data holds between reads
  always_comb begin
    next_rdata = REG_RDATA;
    if (REG_REQ.rd) begin
      case (REG_REQ.addr)
        seqctl_pkg::ADDR_LEVELS: next_rdata = general_output_levels;
        seqctl_pkg::ADDR_DEBOUNCE: next_rdata = input_debounce_config;
        seqctl_pkg::ADDR_PRESS: next_rdata = long_press_threshold;
        seqctl_pkg::ADDR_CONTROL: next_rdata = software_state_control;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // Register file storage; zero until the configuration image arrives
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      general_output_levels <= 8'h00;
      input_debounce_config <= 8'h00;
      long_press_threshold <= 8'h00;
      software_state_control <= 8'h00;
      REG_RDATA <= 8'h00;
    end else begin
      general_output_levels <= next_levels;
      input_debounce_config <= next_debounce;
      long_press_threshold <= next_press;
      software_state_control <= next_control;
      REG_RDATA <= next_rdata;
    end
  end

  // Debounce time for all filters: 5 ms steps, field plus one
  assign debounce_limit = 32'(({28'h0, debounce_time} + 32'h1) * 32'(DEB_STEP_CYCLES));

  // One filter per alternate-function input, each with its own enable
  for (genvar i = 0; i < 3; i++) begin : g_deb
    input_debounce u_deb (
      .clk(MCLK),
      .reset(RESET),
      .raw(AF_PIN_IN[i]),
      .enable(debounce_enable_bits[i]),
      .limit(debounce_limit),
      .level(af_level[i])
    );
  end

  // Button edges on the filtered level; the pin is active low
  assign button_press = button_enabled && button_level_q && !af_level[2];
  assign button_release = button_enabled && !button_level_q && af_level[2];

  // Press timer: counts 100 ms steps while the button is held
  always_comb begin
    next_step_count = 32'h0;
    next_press_steps = 9'h0;
    next_short = 1'b0;
    next_long = 1'b0;
    if (button_press) begin // Timing starts at the falling edge
      next_step_count = 32'h0;
      next_press_steps = 9'h0;
    end else if (button_enabled && !af_level[2]) begin
      next_press_steps = press_steps;
      if (step_count + 32'h1 >= 32'(PRESS_STEP_CYCLES)) begin
        // Saturate well past the largest threshold
        next_press_steps = (press_steps == 9'h1ff) ? press_steps : press_steps + 9'h1;
      end else begin
        next_step_count = step_count + 32'h1;
      end
    end else if (button_release) begin // Classify at release
      if (press_steps >= {1'b0, long_press_threshold} + 9'h1) begin
        next_long = 1'b1;
      end else begin
        next_short = 1'b1;
      end
    end
  end

  // Press timer storage and classification pulses
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      button_level_q <= 1'b1;
      step_count <= 32'h0;
      press_steps <= 9'h0;
      SHORT_PRESS <= 1'b0;
      LONG_PRESS <= 1'b0;
    end else begin
      button_level_q <= af_level[2];
      step_count <= next_step_count;
      press_steps <= next_press_steps;
      SHORT_PRESS <= next_short;
      LONG_PRESS <= next_long;
    end
  end

  // Forced shutdown sequencer; button mode is captured at the start so a
  // pin reconfiguration mid-sequence cannot switch the restart policy
  always_comb begin
    next_fs_state = fs_state;
    next_delay_count = 32'h0;
    next_fs_button_mode = fs_button_mode;
    next_fs_code = fs_code;
    next_pd_req = 1'b0;
    next_pu_req = 1'b0;
    next_override = 1'b0;
    shutdown_done = 1'b0;
    case (fs_state)
      FS_IDLE: begin
        // Code 00b leaves active pin or button in normal control
        if (forced_shutdown_code != seqctl_pkg::SHDN_NONE) begin
          next_fs_state = FS_POWERDOWN;
          next_fs_code = forced_shutdown_code;
          next_fs_button_mode = button_enabled;
          next_pd_req = 1'b1;
          next_override = 1'b1;
        end
      end
      FS_POWERDOWN: begin
        next_pd_req = 1'b1;
        next_override = 1'b1;
        if (POWERDOWN_DONE) begin
          next_pd_req = 1'b0;
          case (fs_code)
            seqctl_pkg::SHDN_DELAY: next_fs_state = FS_DELAY;
            seqctl_pkg::SHDN_WAIT: next_fs_state = FS_WAIT_EVENT;
            default: begin // Code 01b: restore or power up at once
              next_fs_state = FS_IDLE;
              next_override = 1'b0;
              next_pu_req = fs_button_mode;
              shutdown_done = 1'b1;
            end
          endcase
        end
      end
      FS_DELAY: begin
        next_override = 1'b1;
        next_delay_count = delay_count + 32'h1;
        // One second, cut short by a press in button mode
        if (delay_count + 32'h1 >= 32'(RESTART_DELAY_CYCLES) ||
            (fs_button_mode && button_press)) begin
          next_fs_state = FS_IDLE;
          next_override = 1'b0;
          next_pu_req = fs_button_mode;
          next_delay_count = 32'h0;
          shutdown_done = 1'b1;
        end
      end
      FS_WAIT_EVENT: begin
        next_override = 1'b1;
        // Alarm, or active pin low without button, or a press with it
        if (RTC_ALARM || (fs_button_mode ? button_press : !ACTIVE_REQUEST_PIN)) begin
          next_fs_state = FS_IDLE;
          next_override = 1'b0;
          next_pu_req = fs_button_mode;
          shutdown_done = 1'b1;
        end
      end
      default: begin
        next_fs_state = FS_IDLE;
      end
    endcase
  end

  // Static output levels and ownership for every channel
  always_comb begin
    next_out_level = 12'h000;
    next_out_select = 12'h000;
    // Register nibbles map to channels 4..1 and 12..9
    next_out_level[3:0] = general_output_levels[seqctl_pkg::LVL_LOW_CH_LSB +: 4];
    next_out_level[11:8] = general_output_levels[seqctl_pkg::LVL_HIGH_CH_LSB +: 4];
    for (int ch = 0; ch < seqctl_pkg::NUM_CHANNELS; ch++) begin
      // Output owns the pin only with both sequencing enables clear
      next_out_select[ch] = !POWERUP_CHANNEL_ENABLE[ch] && !SLEEP_CHANNEL_ENABLE[ch] &&
                            (ch < 4 || ch >= 8);
    end
    // Pins 12..9 also need the alternate function enabled and set to output
    next_out_select[11:8] = next_out_select[11:8] & ALTFUNC_ENABLE & ~ALTFUNC_SELECT;
    next_out_level = next_out_level & next_out_select;
  end

  // Sequencer, pin and status registers; every output leaves from a flop
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      fs_state <= FS_IDLE;
      delay_count <= 32'h0;
      fs_button_mode <= 1'b0;
      fs_code <= seqctl_pkg::SHDN_NONE;
      POWERDOWN_REQUEST <= 1'b0;
      POWERUP_REQUEST <= 1'b0;
      ACTIVE_OVERRIDE <= 1'b0;
      STATIC_OUTPUT_LEVEL <= 12'h000;
      STATIC_OUTPUT_SELECT <= 12'h000;
      AF_INPUT_LEVEL <= 3'h7;
      INTERRUPT_OUT_N <= 1'b1;
      SLEEP_REQUEST <= 1'b0;
    end else begin
      fs_state <= next_fs_state;
      delay_count <= next_delay_count;
      fs_button_mode <= next_fs_button_mode;
      fs_code <= next_fs_code;
      POWERDOWN_REQUEST <= next_pd_req;
      POWERUP_REQUEST <= next_pu_req;
      ACTIVE_OVERRIDE <= next_override;
      STATIC_OUTPUT_LEVEL <= next_out_level;
      STATIC_OUTPUT_SELECT <= next_out_select;
      AF_INPUT_LEVEL <= af_level;
      INTERRUPT_OUT_N <= !(force_int || INTERRUPT_SOURCE_FLAGS);
      SLEEP_REQUEST <= SLEEP_PIN && !hold_active_bit;
    end
  end

endmodule : sequencer_control_regs

`default_nettype wire

// *** tb/engine_model.sv ***
// Power-down engine model facing the control block.
// Assumes the request is a registered level; the bench picks the delay.
`timescale 1ns/100ps
`default_nettype none

module engine_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic request,
  input wire logic [7:0] delay,
  output logic done
);
  logic [7:0] count; // Cycles spent in the sequence

  // One done pulse per request
  always_ff @(posedge clk) begin
    if (reset || !request) begin
      count <= 8'h00;
      done <= 1'b0;
    end else begin
      count <= (count == delay) ? count : count + 8'h01;
      done <= (count + 8'h01 == delay);
    end
  end
endmodule : engine_model

`default_nettype wire

// *** tb/seqctl_monitor.sv ***
// Port checker of the control register group.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps
`default_nettype none

module seqctl_monitor (
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic INTERRUPT_SOURCE_FLAGS,
  input wire logic SLEEP_PIN,
  input wire logic [11:0] POWERUP_CHANNEL_ENABLE,
  input wire logic [11:0] SLEEP_CHANNEL_ENABLE,
  input wire logic POWERDOWN_DONE,
  input wire logic [2:0] AF_INPUT_LEVEL,
  input wire logic [11:0] STATIC_OUTPUT_LEVEL,
  input wire logic [11:0] STATIC_OUTPUT_SELECT,
  input wire logic SHORT_PRESS,
  input wire logic LONG_PRESS,
  input wire logic INTERRUPT_OUT_N,
  input wire logic SLEEP_REQUEST,
  input wire logic POWERDOWN_REQUEST,
  input wire logic POWERUP_REQUEST,
  input wire logic ACTIVE_OVERRIDE
);
  // One domain, so one clock and one disable for all
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);

  property p_irq; INTERRUPT_SOURCE_FLAGS |=> !INTERRUPT_OUT_N; endproperty
  a_irq: assert property (p_irq) else $error("fault not on interrupt");
  property p_sleep; SLEEP_REQUEST |-> $past(SLEEP_PIN); endproperty
  a_sleep: assert property (p_sleep) else $error("sleep without pin");
  property p_pd_end; POWERDOWN_REQUEST && POWERDOWN_DONE |=> !POWERDOWN_REQUEST; endproperty
  a_pd_end: assert property (p_pd_end) else $error("power-down held");
  property p_pd_ovr; $rose(POWERDOWN_REQUEST) |-> ACTIVE_OVERRIDE; endproperty
  a_pd_ovr: assert property (p_pd_ovr) else $error("override missing");
  property p_pu_len; POWERUP_REQUEST |=> !POWERUP_REQUEST; endproperty
  a_pu_len: assert property (p_pu_len) else $error("power-up too long");
  property p_pu_ord; $rose(POWERUP_REQUEST) |-> !POWERDOWN_REQUEST; endproperty
  a_pu_ord: assert property (p_pu_ord) else $error("power-up early");
  property p_press; SHORT_PRESS || LONG_PRESS |-> AF_INPUT_LEVEL[2] && !(SHORT_PRESS && LONG_PRESS);
  endproperty
  a_press: assert property (p_press) else $error("bad press pulse");
  property p_mask;
    (STATIC_OUTPUT_LEVEL & ~STATIC_OUTPUT_SELECT) == 12'h000 && STATIC_OUTPUT_SELECT[7:4] == 4'h0;
  endproperty
  a_mask: assert property (p_mask) else $error("level on unselected pin");
  // Select lags the enables by one flop
  property p_block;
    (STATIC_OUTPUT_SELECT & $past(POWERUP_CHANNEL_ENABLE | SLEEP_CHANNEL_ENABLE)) == 12'h000;
  endproperty
  a_block: assert property (p_block) else $error("output while enabled");

  c_pu: cover property (POWERUP_REQUEST);
  c_long: cover property (LONG_PRESS);
  c_short: cover property (SHORT_PRESS);
  c_ovr: cover property ($fell(ACTIVE_OVERRIDE));
endmodule : seqctl_monitor

`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench of the control register group.
// Assumes short step parameters so all timed behaviour fits a brief run.
`timescale 1ns/100ps
`default_nettype none

module tb;
  logic mclk = 1'b0, reset = 1'b1, nvm_load = 1'b0, prot = 1'b0;
  seqctl_pkg::nvm_image_s img = '0;
  seqctl_pkg::reg_req_s req = '0;
  logic [3:0] af_en = 4'h0, af_sel = 4'h0;
  logic [11:0] pu_en = 12'h000, sleep_channel_enable = 12'h000, lvl, sel;
  logic [2:0] pins = 3'h7, af_lvl;
  logic flags = 1'b0, pu_entry = 1'b0, act = 1'b1, alarm = 1'b0, slp = 1'b0;
  logic [7:0] rdata, dly = 8'h03;
  logic shp, lgp, irq_n, slp_req, pd_req, pu_req, ovr, pd_done;
  int num_errors = 0, check_count = 0, cycles = 0;

  // 200 MHz clock
  initial forever #2.5 mclk = ~mclk;

  sequencer_control_regs #(.DEB_STEP_CYCLES(20), .PRESS_STEP_CYCLES(50),
    .RESTART_DELAY_CYCLES(100)) uut (
    .MCLK(mclk), .RESET(reset), .NVM_LOAD(nvm_load), .NVM_IMAGE(img),
    .CTL_PROTECTED(prot), .REG_REQ(req), .ALTFUNC_ENABLE(af_en), .ALTFUNC_SELECT(af_sel),
    .POWERUP_CHANNEL_ENABLE(pu_en), .SLEEP_CHANNEL_ENABLE(sleep_channel_enable), .AF_PIN_IN(pins),
    .INTERRUPT_SOURCE_FLAGS(flags), .POWERUP_ENTRY(pu_entry), .POWERDOWN_DONE(pd_done),
    .ACTIVE_REQUEST_PIN(act), .RTC_ALARM(alarm), .SLEEP_PIN(slp), .REG_RDATA(rdata),
    .STATIC_OUTPUT_LEVEL(lvl), .STATIC_OUTPUT_SELECT(sel), .AF_INPUT_LEVEL(af_lvl),
    .SHORT_PRESS(shp), .LONG_PRESS(lgp), .INTERRUPT_OUT_N(irq_n), .SLEEP_REQUEST(slp_req),
    .POWERDOWN_REQUEST(pd_req), .POWERUP_REQUEST(pu_req), .ACTIVE_OVERRIDE(ovr));

  // Sequencing engine stands behind the power-down handshake
  engine_model eng (.clk(mclk), .reset(reset), .request(pd_req), .delay(dly), .done(pd_done));

  task automatic check(input string name, input logic [11:0] exp, input logic [11:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask : check

  task automatic chk1(input string name, input logic exp, input logic got);
    check(name, {11'h000, exp}, {11'h000, got});
  endtask : chk1

  // Waits n edges, then settles
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    req <= {1'b1, 1'b0, a, d};
    @(posedge mclk);
    req <= '0;
  endtask : reg_wr

  // Read data is valid just after the edge that samples the request
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    req <= {1'b0, 1'b1, a, 8'h00};
    @(posedge mclk);
    req <= '0;
    #1;
    check("register read", {4'h0, exp}, {4'h0, rdata});
  endtask : reg_rd

  // Looks for a power-up pulse
  task automatic pu_seen(input int n, input logic exp);
    logic seen;
    #1;
    seen = pu_req;
    repeat (n) begin
      tick(1);
      seen |= pu_req;
    end
    chk1("power-up request", exp, seen);
  endtask : pu_seen

  // Starts a forced power-down and waits for its end
  task automatic force_down(input logic [1:0] code, input logic [7:0] d);
    int i;
    dly <= d;
    reg_wr(8'h28, {6'h00, code});
    for (i = 0; i < 10 && pd_req !== 1'b1; i++) tick(1);
    chk1("override", 1'b1, ovr);
    for (i = 0; i < 300 && pd_req !== 1'b0; i++) tick(1);
    chk1("power-down request", 1'b0, pd_req);
  endtask : force_down

  task automatic press(input int n, input logic exp_long);
    logic s, l;
    @(posedge mclk);
    pins[2] <= 1'b0;
    repeat (n) @(posedge mclk);
    pins[2] <= 1'b1;
    s = 1'b0;
    l = 1'b0;
    repeat (12) begin
      tick(1);
      s |= shp;
      l |= lgp;
    end
    chk1("long press", exp_long, l);
    chk1("short press", !exp_long, s);
  endtask : press

  task automatic final_report;
    $display("checks %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report

  // Hang guard
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      final_report;
    end
  end

  initial begin
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    tick(1);
    chk1("interrupt out", 1'b1, irq_n);
    @(posedge mclk);
    img <= 32'ha5000100;
    nvm_load <= 1'b1;
    af_en <= 4'hf;
    @(posedge mclk);
    nvm_load <= 1'b0;
    reg_rd(8'h25, 8'ha5);
    reg_rd(8'h27, 8'h01);
    chk1("power-down request", 1'b0, pd_req);
    check("static level", 12'h50a, lvl);
    check("static select", 12'hf0f, sel);
    @(posedge mclk);
    pu_en <= 12'h002;
    sleep_channel_enable <= 12'h008;
    af_sel <= 4'h8;
    tick(3);
    check("static select", 12'h705, sel);
    check("static level", 12'h500, lvl);
    @(posedge mclk);
    prot <= 1'b1;
    reg_wr(8'h25, 8'h00);
    reg_rd(8'h25, 8'ha5);
    @(posedge mclk);
    prot <= 1'b0;
    reg_wr(8'h26, 8'hff);
    reg_rd(8'h26, 8'hfe);
    reg_rd(8'h30, 8'h00);
    reg_wr(8'h28, 8'h08);
    tick(2);
    chk1("interrupt out", 1'b0, irq_n);
    reg_wr(8'h28, 8'h00);
    tick(2);
    chk1("interrupt out", 1'b1, irq_n);
    @(posedge mclk);
    flags <= 1'b1;
    slp <= 1'b1;
    tick(3);
    chk1("interrupt out", 1'b0, irq_n);
    chk1("sleep request", 1'b1, slp_req);
    reg_wr(8'h28, 8'h04);
    reg_rd(8'h28, 8'h00);
    @(posedge mclk);
    flags <= 1'b0;
    pu_entry <= 1'b1;
    @(posedge mclk);
    pu_entry <= 1'b0;
    reg_rd(8'h28, 8'h04);
    tick(2);
    chk1("sleep request", 1'b0, slp_req);
    reg_wr(8'h28, 8'h00);
    tick(3);
    chk1("sleep request", 1'b1, slp_req);
    // Debounce: field 1 gives 40 cycles on pin 10; pin 11 unfiltered
    reg_wr(8'h26, 8'h12);
    @(posedge mclk);
    pins[0] <= 1'b0;
    repeat (30) @(posedge mclk);
    pins[0] <= 1'b1;
    tick(50);
    chk1("pin 10 level", 1'b1, af_lvl[0]);
    @(posedge mclk);
    pins[0] <= 1'b0;
    pins[1] <= 1'b0;
    tick(4);
    chk1("pin 11 level", 1'b0, af_lvl[1]);
    tick(46);
    chk1("pin 10 level", 1'b0, af_lvl[0]);
    reg_wr(8'h26, 8'h00);
    // Threshold 1 means 100 cycles
    press(115, 1'b1);
    press(90, 1'b0);
    @(posedge mclk);
    af_en <= 4'h7;
    force_down(2'h1, 8'h03);
    tick(2);
    chk1("override", 1'b0, ovr);
    reg_rd(8'h28, 8'h00);
    force_down(2'h2, 8'h28);
    tick(90);
    chk1("override", 1'b1, ovr);
    tick(20);
    chk1("override", 1'b0, ovr);
    force_down(2'h3, 8'h03);
    tick(20);
    chk1("override", 1'b1, ovr);
    @(posedge mclk);
    act <= 1'b0;
    tick(4);
    chk1("override", 1'b0, ovr);
    @(posedge mclk);
    act <= 1'b1;
    af_en <= 4'hf;
    force_down(2'h1, 8'h03);
    pu_seen(4, 1'b1);
    force_down(2'h2, 8'h03);
    pu_seen(20, 1'b0);
    @(posedge mclk);
    pins[2] <= 1'b0;
    pu_seen(8, 1'b1);
    @(posedge mclk);
    pins[2] <= 1'b1;
    force_down(2'h3, 8'h03);
    pu_seen(40, 1'b0);
    @(posedge mclk);
    alarm <= 1'b1;
    @(posedge mclk);
    alarm <= 1'b0;
    pu_seen(5, 1'b1);
    final_report;
  end
endmodule : tb

bind sequencer_control_regs seqctl_monitor mon (
  .MCLK(MCLK), .RESET(RESET), .INTERRUPT_SOURCE_FLAGS(INTERRUPT_SOURCE_FLAGS),
  .SLEEP_PIN(SLEEP_PIN), .POWERUP_CHANNEL_ENABLE(POWERUP_CHANNEL_ENABLE),
  .SLEEP_CHANNEL_ENABLE(SLEEP_CHANNEL_ENABLE), .POWERDOWN_DONE(POWERDOWN_DONE),
  .AF_INPUT_LEVEL(AF_INPUT_LEVEL), .STATIC_OUTPUT_LEVEL(STATIC_OUTPUT_LEVEL),
  .STATIC_OUTPUT_SELECT(STATIC_OUTPUT_SELECT), .SHORT_PRESS(SHORT_PRESS),
  .LONG_PRESS(LONG_PRESS), .INTERRUPT_OUT_N(INTERRUPT_OUT_N), .SLEEP_REQUEST(SLEEP_REQUEST),
  .POWERDOWN_REQUEST(POWERDOWN_REQUEST), .POWERUP_REQUEST(POWERUP_REQUEST),
  .ACTIVE_OVERRIDE(ACTIVE_OVERRIDE));

`default_nettype wire
